// ==== hw/tmr_defs.svh ====
// Constants for the timer clock front end: register offsets, field positions, reset values.
// Assumes inclusion by the timer package, the timer module and the testbench.
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// Register word offsets on the plain register port.
`define OFS_CTL 4'h0
`define OFS_SRCSEL 4'h1
`define OFS_EVGEN 4'h2
`define OFS_PRESCALE 4'h3
`define OFS_RELOAD 4'h4
`define OFS_REPEAT 4'h5
`define OFS_COUNT 4'h6
`define OFS_FLAGS 4'h7

// Control register bit positions.
`define CTL_RUN 0
`define CTL_UPSUP 1
`define CTL_DIR 4
`define CTL_MODE1 5

// Software event bit position.
`define EVG_UPD 0

// Flag register bit positions.
`define FLG_UPD 0
`define FLG_OVF 1

// Source select layout: seven four-bit fields, index 6 at the top.
`define SEL_W 4
`define SEL_IDX_EXT 6

// Index-6 source codes.
`define SRC_INT 4'h0
`define SRC_ITI0 4'h1
`define SRC_ITI3 4'h4
`define SRC_CH0 4'h5
`define SRC_CH1 4'h6
`define SRC_CHX 4'h7
`define SRC_ETI 4'h8

// Reset values.
`define RST_PRESCALE 16'h0000
`define RST_RELOAD 16'hFFFF
`define RST_REPEAT 8'h00
`define RST_CTL 8'h00
`define RST_SRC 28'h0000000

// Read data for unmapped offsets.
`define RD_UNMAPPED 32'h00000000

`endif

// ==== hw/tmr_pkg.sv ====
// Types for the timer clock front end.
// Assumes the defines header is on the include path.
package tmr_pkg;
    `include "tmr_defs.svh"

    // Edge filter states, Gray coded along the idle-to-high path.
    typedef enum logic [1:0] {
        FLT_LOW = 2'b00,
        FLT_RISE = 2'b01,
        FLT_HIGH = 2'b11,
        FLT_FALL = 2'b10
    } flt_state_t;
endpackage

// ==== hw/adv_timer_front.sv ====
// Clock source selection, 16-bit prescaler and 16-bit up-counter of an advanced timer.
// Assumes a register master on clk_sys, pins arriving asynchronously, and an
// alternate-source select word written by software into this block.
//
// Contract
// - Select zero runs prescaler from kernel clock.
// - Run bit set divides input by prescale.
// - Fields 3,4,5 nonzero keep internal clock.
// - Codes 5,6,7 use channel pin edges.
// - Codes 1..4 use trigger input rises.
// - Mode-one bit selects filtered external trigger.
// - Code 8 also selects external trigger.
// - External trigger filtered, one pulse per rise.
// - Prescale divides by 1 to 65536.
// - New prescale waits for update event.
// - Count 0 to reload, wrap, overflow.
// - Update after repetition plus one overflows.
// - Software update clears counter, raises update.
// - Suppress bit blocks update events.
// - Update loads repetition, reload, prescale shadows.
// - Counter is 16-bit unsigned.
// - Update event drives interrupt and DMA request.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "tmr_defs.svh"

module adv_timer_front #(
    parameter int CNT_W = 16,
    parameter int REP_W = 8,
    parameter int FLT_LEN = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic channel_pin_zero,
    input wire logic channel_pin_one,
    input wire logic [3:0] internal_trigger_inputs,
    input wire logic external_trigger_input,
    output logic counter_tick,
    output logic overflow_pulse,
    output logic update_pulse,
    output logic update_irq,
    output logic update_dma_req,
    output logic trigger_output
);
    import tmr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    // All state of the block in one record.
    typedef struct packed {
        logic [7:0] ctl;                  // Run, suppress, direction, mode one.
        logic [27:0] src;                 // Seven source select fields.
        logic [CNT_W-1:0] psc_pend;       // Prescale as written.
        logic [CNT_W-1:0] psc_act;        // Prescale in use.
        logic [CNT_W-1:0] car_pend;       // Reload as written.
        logic [CNT_W-1:0] car_act;        // Reload in use.
        logic [REP_W-1:0] rep_pend;       // Repetition as written.
        logic [REP_W-1:0] rep_act;        // Repetition in use.
        logic [REP_W-1:0] rep_cnt;        // Overflows still to go.
        logic [CNT_W-1:0] pdiv;           // Prescaler divider count.
        logic [CNT_W-1:0] cnt;            // Main counter.
        logic [1:0] flags;                // Sticky update and overflow flags.
        logic [5:0] s1;                   // First synchroniser stage.
        logic [5:0] s2;                   // Second synchroniser stage.
        logic [5:0] s3;                   // Previous synchronised level.
        flt_state_t flt;                  // External trigger filter state.
        logic [$clog2(FLT_LEN+1)-1:0] fcnt; // Filter stability count.
        logic [31:0] rdata;               // Read data.
        logic tick;                       // Counter tick pulse.
        logic ovf;                        // Overflow pulse.
        logic upd;                        // Update pulse.
    } st_t;

    st_t st_reg;
    st_t st_next;

    // Decoded helpers.
    logic [3:0] sel6;                      // Index-6 source code.
    logic alt_any;                         // Any of fields 0,1,2,6 nonzero.
    logic eti_sel;                         // External trigger selected.
    logic src_edge;                        // Selected prescaler input event.
    logic [5:0] rise;                      // Rising edges of synchronised inputs.
    logic [5:0] fall;                      // Falling edges of synchronised inputs.
    logic eti_rise;                        // Filtered external trigger rising edge.
    logic sw_upd;                          // Software update request.
    logic wr_flags;                        // Flag register written.
    logic [31:0] rmux;                     // Read mux.
    logic [CNT_W:0] fullw;                 // Widened filter-length constant.

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // One process computes every next value; the order of blocks sets priority.
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        st_next.ovf = 1'b0;
        st_next.upd = 1'b0;
        fullw = (CNT_W+1)'(FLT_LEN);

        // Pins other than channel pin one, which is not sampled, pass two flip-flops; edges compare the second stage with the third, s3.
        st_next.s1 = {external_trigger_input, internal_trigger_inputs,
                      channel_pin_one ^ channel_pin_zero};
        st_next.s1 = {external_trigger_input, internal_trigger_inputs, channel_pin_zero};
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        rise = st_reg.s2 & ~st_reg.s3;
        fall = ~st_reg.s2 & st_reg.s3;

        // External trigger filter: a level must hold FLT_LEN+1 cycles to count.
        eti_rise = 1'b0;
        unique case (st_reg.flt)
            FLT_LOW: begin
                st_next.fcnt = '0;
                if (st_reg.s2[5]) begin
                    st_next.flt = FLT_RISE;
                end
            end
            FLT_RISE: begin
                if (!st_reg.s2[5]) begin
                    st_next.flt = FLT_LOW;
                end else if ((CNT_W+1)'(st_reg.fcnt) >= fullw - 1'b1) begin
                    st_next.flt = FLT_HIGH;
                    eti_rise = 1'b1;
                end else begin
                    st_next.fcnt = st_reg.fcnt + 1'b1;
                end
            end
            FLT_HIGH: begin
                st_next.fcnt = '0;
                if (!st_reg.s2[5]) begin
                    st_next.flt = FLT_FALL;
                end
            end
            FLT_FALL: begin
                if (st_reg.s2[5]) begin
                    st_next.flt = FLT_HIGH;
                end else if ((CNT_W+1)'(st_reg.fcnt) >= fullw - 1'b1) begin
                    st_next.flt = FLT_LOW;
                end else begin
                    st_next.fcnt = st_reg.fcnt + 1'b1;
                end
            end
        endcase

        // Source selection. Fields 3..5 never leave the internal clock.
        sel6 = st_reg.src[`SEL_IDX_EXT*`SEL_W +: `SEL_W];
        alt_any = (st_reg.src[0 +: 3*`SEL_W] != '0) || (sel6 != `SRC_INT);
        eti_sel = st_reg.ctl[`CTL_MODE1] || (sel6 == `SRC_ETI);
        if (eti_sel) begin
            src_edge = eti_rise;
        end else if (!alt_any) begin
            src_edge = 1'b1;
        end else if (sel6 >= `SRC_ITI0 && sel6 <= `SRC_ITI3) begin
            src_edge = rise[1 + 32'(sel6 - `SRC_ITI0)];
        end else if (sel6 == `SRC_CH0) begin
            src_edge = rise[0];
        end else if (sel6 == `SRC_CH1) begin
            src_edge = fall[0];
        end else if (sel6 == `SRC_CHX) begin
            src_edge = rise[0] | fall[0];
        end else begin
            src_edge = 1'b1;
        end

        // Register writes.
        sw_upd = reg_wr && reg_addr == `OFS_EVGEN && reg_wdata[`EVG_UPD];
        wr_flags = reg_wr && reg_addr == `OFS_FLAGS;
        if (reg_wr) begin
            unique case (reg_addr)
                `OFS_CTL: st_next.ctl = reg_wdata[7:0];
                `OFS_SRCSEL: st_next.src = reg_wdata[27:0];
                `OFS_PRESCALE: st_next.psc_pend = reg_wdata[CNT_W-1:0];
                `OFS_RELOAD: st_next.car_pend = reg_wdata[CNT_W-1:0];
                `OFS_REPEAT: st_next.rep_pend = reg_wdata[REP_W-1:0];
                default: ;
            endcase
        end
        // Writing one clears a flag.
        if (wr_flags) begin
            st_next.flags = st_reg.flags & ~reg_wdata[1:0];
        end

        // Prescaler: factor is stored value plus one.
        if (st_reg.ctl[`CTL_RUN] && src_edge) begin
            if (st_reg.pdiv >= st_reg.psc_act) begin
                st_next.pdiv = '0;
                st_next.tick = 1'b1;
            end else begin
                st_next.pdiv = st_reg.pdiv + 1'b1;
            end
        end

        // Counter on each tick; 16-bit unsigned.
        if (st_reg.tick) begin
            if (st_reg.cnt >= st_reg.car_act) begin
                st_next.cnt = '0;
                st_next.ovf = 1'b1;
                st_next.flags[`FLG_OVF] = 1'b1;
                if (st_reg.rep_cnt == '0) begin
                    st_next.upd = !st_reg.ctl[`CTL_UPSUP];
                    st_next.rep_cnt = st_reg.rep_act;
                end else begin
                    st_next.rep_cnt = st_reg.rep_cnt - 1'b1;
                end
            end else begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end
        end

        // Software update wins over a tick in the same cycle.
        if (sw_upd) begin
            st_next.cnt = '0;
            st_next.pdiv = '0;
            st_next.upd = !st_reg.ctl[`CTL_UPSUP];
        end

        // Shadow load on update; the set of a flag wins over a clear.
        if (st_next.upd) begin
            st_next.psc_act = st_next.psc_pend;
            st_next.car_act = st_next.car_pend;
            st_next.rep_act = st_next.rep_pend;
            st_next.rep_cnt = st_next.rep_pend;
            st_next.flags[`FLG_UPD] = 1'b1;
        end

        // Read data one cycle after the strobe.
        unique case (reg_addr)
            `OFS_CTL: rmux = {24'h000000, st_reg.ctl};
            `OFS_SRCSEL: rmux = {4'h0, st_reg.src};
            `OFS_PRESCALE: rmux = {16'h0000, st_reg.psc_pend};
            `OFS_RELOAD: rmux = {16'h0000, st_reg.car_pend};
            `OFS_REPEAT: rmux = {24'h000000, st_reg.rep_pend};
            `OFS_COUNT: rmux = {16'h0000, st_reg.cnt};
            `OFS_FLAGS: rmux = {30'h0, st_reg.flags};
            default: rmux = `RD_UNMAPPED;
        endcase
        st_next.rdata = reg_rd ? rmux : 32'h00000000;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Synchronous reset loads constants only.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.ctl <= `RST_CTL;
            st_reg.src <= `RST_SRC;
            st_reg.psc_pend <= `RST_PRESCALE;
            st_reg.psc_act <= `RST_PRESCALE;
            st_reg.car_pend <= `RST_RELOAD;
            st_reg.car_act <= `RST_RELOAD;
            st_reg.rep_pend <= `RST_REPEAT;
            st_reg.rep_act <= `RST_REPEAT;
            st_reg.rep_cnt <= `RST_REPEAT;
            st_reg.flt <= FLT_LOW;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Every output comes from a flip-flop.
    assign reg_rdata = st_reg.rdata;
    assign counter_tick = st_reg.tick;
    assign overflow_pulse = st_reg.ovf;
    assign update_pulse = st_reg.upd;
    assign update_irq = st_reg.flags[`FLG_UPD];
    assign update_dma_req = st_reg.upd;
    assign trigger_output = st_reg.upd;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    // A software update clears the counter next cycle.
    AST_SWUPD_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sw_upd |=> (st_reg.cnt == '0))
        else $error("software update did not clear counter");

    // Suppression blocks every update.
    AST_SUPPRESS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_reg.ctl[`CTL_UPSUP] && !reg_wr |=> !st_reg.upd)
        else $error("update raised while suppressed");

    // Update loads every shadow from its pending copy.
    AST_SHADOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_reg.upd |-> st_reg.psc_act == st_reg.psc_pend &&
        st_reg.car_act == st_reg.car_pend && st_reg.rep_act == st_reg.rep_pend)
        else $error("shadow registers not loaded on update");

    // Pending prescale never reaches the active copy without update.
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !st_reg.upd |-> $stable(st_reg.psc_act))
        else $error("prescale changed without update");

    // Overflow comes from the reload value and counter returns to zero.
    AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_reg.ovf |-> st_reg.cnt == '0)
        else $error("overflow without wrap to zero");

    // Counter steps by one on a tick below reload.
    AST_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_reg.tick && st_reg.cnt < st_reg.car_act && !sw_upd |=>
        st_reg.cnt == $past(st_reg.cnt) + 1'b1)
        else $error("counter did not step");

    // No tick while stopped.
    AST_RUN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !st_reg.ctl[`CTL_RUN] |=> !st_reg.tick)
        else $error("tick while stopped");

    // Internal source at divide by one ticks every cycle.
    AST_INTCLK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_reg.ctl[`CTL_RUN] && !alt_any && !eti_sel && st_reg.psc_act == '0 && !sw_upd
        |=> st_reg.tick)
        else $error("internal clock did not tick");

    // Overflow pulses last one cycle unless the active reload value is zero.
    AST_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_reg.ovf |=> !st_reg.ovf || st_reg.car_act == '0)
        else $error("overflow pulse too long");

    // Each update leaves the readable update flag set.
    AST_UPD_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_reg.upd |-> st_reg.flags[`FLG_UPD])
        else $error("update flag not set on update");
endmodule

// ==== tb/adv_timer_front_tb.sv ====
// Self-checking bench for the timer clock front end: registers, sources, prescaler, counter.
// Assumes the defines header is on the include path and the design's default parameters.
`timescale 1ns/1ps
`include "tmr_defs.svh"

module adv_timer_front_tb;
    import tmr_pkg::*;
    // ----------------------------------------------------------------
    // Ports, model state and counters
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [6:0] pins = 7'h00; // Pin order: eti, ch1, ch0, iti[3:0].
    logic counter_tick, overflow_pulse, update_pulse, update_irq, update_dma_req, trigger_output;
    logic [31:0] rd, seed = 32'hFDEA6DCA;
    int fails = 0, checks = 0;
    int act_p = 0, act_r = 65535, act_n = 0, pend_p = 0, pend_r = 65535, pend_n = 0;
    int gap = 0, tick_run = 0, ovf_run = 0, ticks = 0;
    bit mon_on = 0, gap_ok = 0, ovf_ok = 0, upd_ok = 0, supp = 0, soft_pend = 0;

    adv_timer_front uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .channel_pin_zero(pins[4]), .channel_pin_one(pins[5]),
        .internal_trigger_inputs(pins[3:0]), .external_trigger_input(pins[6]),
        .counter_tick(counter_tick), .overflow_pulse(overflow_pulse),
        .update_pulse(update_pulse), .update_irq(update_irq),
        .update_dma_req(update_dma_req), .trigger_output(trigger_output));

    // A 200 MHz clock.
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // One comparison; a mismatch is reported at once and counted.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A write is one strobe cycle; the next task waits an edge before raising a strobe again.
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // Pending copies change after the taking edge, as the design's do.
        if (a == `OFS_PRESCALE) pend_p <= d[15:0];
        if (a == `OFS_RELOAD) pend_r <= d[15:0];
        if (a == `OFS_REPEAT) pend_n <= d[7:0];
    endtask

    // Read data stand only in the cycle after the strobe, so sample at the following edge.
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask

    // The mark lands at the taking edge, so an update already on its way is not
    // mistaken for the software one.
    task automatic soft_update();
        reg_write(`OFS_EVGEN, 32'h1 << `EVG_UPD);
        soft_pend <= 1;
    endtask

    task automatic results();
        $display("Checks %0d, fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Event model: ticks, overflows and updates checked against the shadow values
    // ----------------------------------------------------------------
    // Overflow is handled before update and update before tick, because a tick in the
    // cycle that shows the wrapped counter belongs to the next period.
    always @(posedge clk_sys) begin
        if (rst_n) begin
            check(update_dma_req, update_pulse);
            check(trigger_output, update_pulse);
            if (overflow_pulse === 1'b1) begin
                if (mon_on && ovf_ok) check(tick_run, act_r + 1);
                tick_run = 0;
                ovf_ok = 1;
                ovf_run++;
                if (mon_on && upd_ok && !supp && !soft_pend) check(update_pulse, ovf_run == act_n + 1);
            end
            if (update_pulse === 1'b1) begin
                if (mon_on && upd_ok && !soft_pend) check(ovf_run, act_n + 1);
                if (mon_on) check(supp, 0);
                act_p = pend_p;
                act_r = pend_r;
                act_n = pend_n;
                ovf_ok = !soft_pend;
                soft_pend = 0;
                ovf_run = 0;
                tick_run = 0;
                upd_ok = 1;
                gap_ok = 0;
            end
            if (counter_tick === 1'b1) begin
                if (mon_on && gap_ok) check(gap, act_p + 1);
                gap = 0;
                gap_ok = 1;
                tick_run++;
                ticks++;
            end
            gap++;
        end
    end

    // A hang is cut short well beyond the expected run length.
    initial begin
        #400us;
        fails++;
        results();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int word, pin, edge_m, m1, exp_t, t0;
        logic [6:0] nv;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset values and unmapped places, which read zero and ignore writes.
        reg_read(`OFS_PRESCALE, rd);
        check(rd, `RST_PRESCALE);
        reg_read(`OFS_RELOAD, rd);
        check(rd, `RST_RELOAD);
        reg_read(`OFS_REPEAT, rd);
        check(rd, `RST_REPEAT);
        reg_read(`OFS_COUNT, rd);
        check(rd, 32'h00000000);
        for (int a = 8; a < 16; a++) begin
            reg_write(a[3:0], 32'hFFFFFFFF);
            reg_read(a[3:0], rd);
            check(rd, `RD_UNMAPPED);
        end
        // The full 16-bit factor is accepted.
        reg_write(`OFS_PRESCALE, 32'h0000FFFF);
        reg_read(`OFS_PRESCALE, rd);
        check(rd, 32'h0000FFFF);
        // Internal clock, divided and counted; then new values pending while running.
        reg_write(`OFS_PRESCALE, 32'h2);
        reg_write(`OFS_RELOAD, 32'h4);
        reg_write(`OFS_REPEAT, 32'h1);
        reg_write(`OFS_CTL, 32'h1 << `CTL_RUN);
        soft_update();
        mon_on = 1;
        repeat (300) @(posedge clk_sys);
        reg_write(`OFS_PRESCALE, 32'h0);
        reg_write(`OFS_RELOAD, 32'h2);
        reg_write(`OFS_REPEAT, 32'h0);
        repeat (300) @(posedge clk_sys);
        // Random shadow sets, each left to take effect at a natural update.
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            reg_write(`OFS_PRESCALE, seed[1:0]);
            reg_write(`OFS_RELOAD, seed[4:2] | 32'h1);
            reg_write(`OFS_REPEAT, seed[6:5] % 3);
            repeat (500) @(posedge clk_sys);
            reg_read(`OFS_COUNT, rd);
            check(rd <= act_r, 1);
        end
        // Update suppressed: no update pulse, even for a software request.
        reg_write(`OFS_CTL, (32'h1 << `CTL_RUN) | (32'h1 << `CTL_UPSUP));
        // The first suppressed update would show one edge later; mark it then.
        @(posedge clk_sys);
        supp <= 1;
        reg_write(`OFS_FLAGS, 32'h3);
        repeat (200) @(posedge clk_sys);
        reg_write(`OFS_EVGEN, 32'h1 << `EVG_UPD);
        // The suppressed request still clears counter and divider mid-period.
        ovf_ok <= 0;
        gap_ok <= 0;
        repeat (4) @(posedge clk_sys);
        reg_read(`OFS_FLAGS, rd);
        check(rd[`FLG_UPD], 1'b0);
        check(rd[`FLG_OVF], 1'b1);
        check(update_irq, 1'b0);
        reg_write(`OFS_CTL, 32'h1 << `CTL_RUN);
        @(posedge clk_sys);
        supp <= 0;
        upd_ok <= 0;
        soft_update();
        repeat (4) @(posedge clk_sys);
        reg_read(`OFS_FLAGS, rd);
        check(rd[`FLG_UPD], 1'b1);
        check(update_irq, 1'b1);
        // Clock sources, one per case, with random pin activity; divide by one is made
        // active by a software update so that each source event gives one tick.
        reg_write(`OFS_PRESCALE, 32'h0);
        soft_update();
        mon_on = 0;
        for (int i = 0; i < 12; i++) begin
            word = 0;
            pin = -1;
            edge_m = (i == 8) ? 1 : ((i == 9) ? 2 : 0);
            m1 = (i == 11);
            if (i == 1) word = 32'h0001000;
            if (i == 2) word = 32'h9000000;
            if (i >= 3 && i <= 10) begin
                word = (i - 2) << 24;
                pin = (i < 7) ? i - 3 : ((i == 10) ? 6 : 4);
            end
            if (m1) pin = 6;
            pins <= 7'h00;
            reg_write(`OFS_SRCSEL, word);
            reg_write(`OFS_CTL, (32'h1 << `CTL_RUN) | (m1 << `CTL_MODE1));
            repeat (12) @(posedge clk_sys);
            t0 = ticks;
            exp_t = 0;
            for (int s = 0; s < 25; s++) begin
                seed = lfsr(seed);
                nv = (s == 24) ? 7'h00 : seed[6:0];
                if (pin >= 0 && edge_m != 1 && !pins[pin] && nv[pin]) exp_t++;
                if (pin >= 0 && edge_m != 0 && pins[pin] && !nv[pin]) exp_t++;
                @(posedge clk_sys);
                pins <= nv;
                repeat (7) @(posedge clk_sys);
            end
            repeat (12) @(posedge clk_sys);
            if (pin < 0) begin
                check((ticks - t0) > 180 && (ticks - t0) < 240, 1);
            end else begin
                check(ticks - t0, exp_t);
            end
        end
        results();
    end
endmodule
